// File: shared/lcdt_map.svh
// Constants of the LCD display RAM and frame timing block.
// Assumes inclusion by bare name from the core.
`ifndef LCDT_MAP_SVH
`define LCDT_MAP_SVH

// ============================================================
// Geometry and timing
`define LCDT_COLS      40
`define LCDT_ROWS      4
`define LCDT_FR_DIV    24
`define LCDT_OSC_HALF  8

// ============================================================
// Register byte addresses
`define LCDT_ADR_CTRL  12'h000
`define LCDT_ADR_STAT  12'h004
`define LCDT_ADR_RAM   12'h100

// ============================================================
// Fields and reset values
`define LCDT_CTRL_EN   0
`define LCDT_CTRL_RST  1'b1
`define LCDT_ST_PTR    0
`define LCDT_ST_SUB    8
`define LCDT_ST_ROW    16
`define LCDT_ST_MODE   20
`define LCDT_ST_EXT    24

`endif

// File: shared/lcdt_pkg.sv
// Types shared by the LCD display RAM and frame timing block.
// Assumes nothing beyond a SystemVerilog compiler.
package lcdt_pkg;

	// ============================================================
	// Drive modes, as delivered by the command decoder
	typedef enum logic [1:0] {
		LCDT_STATIC,
		LCDT_MUX2,
		LCDT_MUX3,
		LCDT_MUX4
	} lcdt_mode_t;

endpackage : lcdt_pkg

// File: hdl/lcdt_core.sv
// Display RAM, byte packing, pointer and frame timing of a segment LCD driver.
// Assumes a command decoder on clk_i and pads that resolve the two-way pins.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`include "lcdt_map.svh"
`timescale 1ns/10ps
`default_nettype none

module lcdt_core
	import lcdt_pkg::*;
#(
	parameter int COLS     = `LCDT_COLS,
	parameter int FR_DIV   = `LCDT_FR_DIV,
	parameter int OSC_HALF = `LCDT_OSC_HALF
) (
	// Clock, reset, enable
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,
	// Wishbone slave
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [11:0]   wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	// Clock source pins
	input  wire logic          oscillator_select_pin_i,
	input  wire logic          clk_pin_i,
	output logic               clk_pin_o,
	output logic               clk_pin_oe_o,
	// Open-drain frame sync pin
	input  wire logic          sync_pin_i,
	output logic               sync_pin_o,
	output logic               sync_pin_oe_o,
	// Hardware subaddress straps
	input  wire logic          hw_subaddr_bit_0_i,
	input  wire logic          hw_subaddr_bit_1_i,
	input  wire logic          hw_subaddr_bit_2_i,
	// Command decoder side
	input  wire lcdt_mode_t    mode_i,
	input  wire logic          ptr_load_i,
	input  wire logic [5:0]    ptr_val_i,
	input  wire logic          sub_load_i,
	input  wire logic [2:0]    sub_val_i,
	input  wire logic          byte_stb_i,
	input  wire logic [7:0]    byte_i,
	output logic               byte_ack_o,
	// Display drive
	output logic               backplane_out_0_o,
	output logic               backplane_out_1_o,
	output logic               backplane_out_2_o,
	output logic               backplane_out_3_o,
	output logic [COLS-1:0]    segment_out_o,
	output logic               frame_rate_o
);

	// ============================================================
	// Pin synchronisers
	// Bit order: 5 select, 4 clock pin, 3 sync, 2..0 subaddress
	localparam int P_OSC  = 5;
	localparam int P_CLK  = 4;
	localparam int P_SYNC = 3;

	logic [5:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
	logic [5:0] s1_next, s2_next, s3_next, filt_next, prev_next;
	logic [5:0] agree;

	always_comb begin
		s1_next = {oscillator_select_pin_i, clk_pin_i, sync_pin_i,
		           hw_subaddr_bit_2_i, hw_subaddr_bit_1_i, hw_subaddr_bit_0_i};
		s2_next = s1_reg;
		s3_next = s2_reg;
		// Only a level seen by both late stages counts
		agree = ~(s2_reg ^ s3_reg);
		filt_next = (s2_reg & agree) | (filt_reg & ~agree);
		prev_next = filt_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg   <= 6'h00;
			s2_reg   <= 6'h00;
			s3_reg   <= 6'h00;
			filt_reg <= 6'h00;
			prev_reg <= 6'h00;
		end else if (ce_i) begin
			s1_reg   <= s1_next;
			s2_reg   <= s2_next;
			s3_reg   <= s3_next;
			filt_reg <= filt_next;
			prev_reg <= prev_next;
		end
	end

	logic       ext_clk;
	logic [2:0] hw_sub;
	assign ext_clk = filt_reg[P_OSC];
	assign hw_sub  = filt_reg[2:0];

	// ============================================================
	// Clock source, frame divider and row sequencing
	logic [15:0] osc_cnt_reg, osc_cnt_next;
	logic        clk_out_reg, clk_out_next;
	logic        clk_oe_reg, clk_oe_next;
	logic [4:0]  fdiv_reg, fdiv_next;
	logic [1:0]  row_reg, row_next;
	logic        fr_reg, fr_next;
	logic        sync_oe_reg, sync_oe_next;
	logic        tick;
	logic [1:0]  row_max;

	always_comb begin
		unique case (mode_i)
			LCDT_STATIC: row_max = 2'd0;
			LCDT_MUX2:   row_max = 2'd1;
			LCDT_MUX3:   row_max = 2'd2;
			LCDT_MUX4:   row_max = 2'd3;
		endcase
	end

	always_comb begin
		osc_cnt_next = osc_cnt_reg;
		clk_out_next = clk_out_reg;
		tick         = 1'b0;
		clk_oe_next  = ~ext_clk;
		if (ext_clk) begin
			// Oscillator parked; rising edges of the pin time the block
			osc_cnt_next = 16'h0000;
			clk_out_next = 1'b0;
			tick = filt_reg[P_CLK] & ~prev_reg[P_CLK];
		end else if (osc_cnt_reg == 16'(OSC_HALF - 1)) begin
			osc_cnt_next = 16'h0000;
			clk_out_next = ~clk_out_reg;
			tick = ~clk_out_reg;
		end else begin
			osc_cnt_next = osc_cnt_reg + 16'h0001;
		end
	end

	always_comb begin
		fdiv_next = fdiv_reg;
		row_next  = row_reg;
		fr_next   = 1'b0;
		if (tick) begin
			if (fdiv_reg == 5'(FR_DIV - 1)) begin
				fdiv_next = 5'h00;
				fr_next   = 1'b1;
				row_next  = (row_reg >= row_max) ? 2'd0 : row_reg + 2'd1;
			end else begin
				fdiv_next = fdiv_reg + 5'h01;
			end
		end
		// A mode change may leave the row out of range
		if (row_next > row_max) begin
			row_next = 2'd0;
		end
		// Another driver started its frame: line up with it
		if (~filt_reg[P_SYNC] & prev_reg[P_SYNC] & (row_reg != 2'd0)) begin
			row_next  = 2'd0;
			fdiv_next = 5'h00;
		end
		sync_oe_next = (row_next == 2'd0) && (fdiv_next == 5'h00);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_cnt_reg <= 16'h0000;
			clk_out_reg <= 1'b0;
			clk_oe_reg  <= 1'b0;
			fdiv_reg    <= 5'h00;
			row_reg     <= 2'd0;
			fr_reg      <= 1'b0;
			sync_oe_reg <= 1'b0;
		end else if (ce_i) begin
			osc_cnt_reg <= osc_cnt_next;
			clk_out_reg <= clk_out_next;
			clk_oe_reg  <= clk_oe_next;
			fdiv_reg    <= fdiv_next;
			row_reg     <= row_next;
			fr_reg      <= fr_next;
			sync_oe_reg <= sync_oe_next;
		end
	end

	// ============================================================
	// Byte packing into the display RAM
	logic [5:0] ptr_reg, ptr_next;
	logic [2:0] sub_reg, sub_next;
	logic       ack_reg, ack_next;
	logic [3:0] ram_reg [COLS];
	logic [3:0] ram_next [COLS];

	logic [5:0] hit_col [8];
	logic [1:0] hit_row [8];
	logic [7:0] hit_en;
	logic       sub_match, sub_match_nx;

	assign sub_match    = (sub_reg == hw_sub);
	assign sub_match_nx = ((sub_reg + 3'd1) == hw_sub);

	// Received bit 7 lands first: lowest column, lowest row
	for (genvar b = 0; b < 8; b++) begin : g_bit
		localparam int IDX = 7 - b;
		logic [2:0] off;
		logic [1:0] r;
		logic [5:0] abs_col;
		logic       wrap;
		always_comb begin
			unique case (mode_i)
				LCDT_STATIC: begin
					off = 3'(IDX);
					r   = 2'd0;
				end
				LCDT_MUX2: begin
					off = 3'(IDX / 2);
					r   = 2'(IDX % 2);
				end
				LCDT_MUX3: begin
					off = 3'(IDX / 3);
					r   = 2'(IDX % 3);
				end
				LCDT_MUX4: begin
					off = 3'(IDX / 4);
					r   = 2'(IDX % 4);
				end
			endcase
			abs_col = ptr_reg + {3'h0, off};
			wrap    = (abs_col >= 6'(COLS));
		end
		// Bits past the end belong to the next subaddress
		assign hit_col[b] = wrap ? abs_col - 6'(COLS) : abs_col;
		assign hit_row[b] = r;
		assign hit_en[b]  = byte_stb_i & (wrap ? sub_match_nx : sub_match);
	end

	logic [6:0] ptr_sum;
	logic [6:0] ptr_inc;

	always_comb begin
		for (int c = 0; c < COLS; c++) begin
			ram_next[c] = ram_reg[c];
		end
		for (int b = 0; b < 8; b++) begin
			if (hit_en[b]) begin
				ram_next[hit_col[b]][hit_row[b]] = byte_i[b];
			end
		end
	end

	always_comb begin
		unique case (mode_i)
			LCDT_STATIC: ptr_inc = 7'd8;
			LCDT_MUX2:   ptr_inc = 7'd4;
			LCDT_MUX3:   ptr_inc = 7'd3;
			LCDT_MUX4:   ptr_inc = 7'd2;
		endcase
		ptr_sum  = {1'b0, ptr_reg} + ptr_inc;
		ptr_next = ptr_reg;
		sub_next = sub_reg;
		ack_next = byte_stb_i & (|hit_en);
		if (byte_stb_i) begin
			// Advances whether or not this device stored
			if (ptr_sum >= 7'(COLS)) begin
				ptr_next = 6'(ptr_sum - 7'(COLS));
				sub_next = sub_reg + 3'd1;
			end else begin
				ptr_next = ptr_sum[5:0];
			end
		end
		// Decoder loads win over a same-cycle advance
		if (ptr_load_i) begin
			ptr_next = ptr_val_i;
		end
		if (sub_load_i) begin
			sub_next = sub_val_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_reg <= 6'h00;
			sub_reg <= 3'h0;
			ack_reg <= 1'b0;
			for (int c = 0; c < COLS; c++) begin
				ram_reg[c] <= 4'h0;
			end
		end else if (ce_i) begin
			ptr_reg <= ptr_next;
			sub_reg <= sub_next;
			ack_reg <= ack_next;
			for (int c = 0; c < COLS; c++) begin
				ram_reg[c] <= ram_next[c];
			end
		end
	end

	// ============================================================
	// Register bus
	logic        en_reg, en_next;
	logic        wb_ack_reg, wb_ack_next;
	logic [31:0] wb_dat_reg, wb_dat_next;
	logic        bus_hit;
	logic [11:0] ram_off;
	logic [9:0]  ram_idx;

	assign bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
	assign ram_off = wb_adr_i - `LCDT_ADR_RAM;
	assign ram_idx = ram_off[11:2];

	always_comb begin
		en_next     = en_reg;
		wb_ack_next = bus_hit;
		wb_dat_next = 32'h0000_0000;
		if (bus_hit) begin
			if (wb_adr_i == `LCDT_ADR_CTRL) begin
				wb_dat_next[`LCDT_CTRL_EN] = en_reg;
				if (wb_we_i & wb_sel_i[0]) begin
					en_next = wb_dat_i[`LCDT_CTRL_EN];
				end
			end else if (wb_adr_i == `LCDT_ADR_STAT) begin
				wb_dat_next = (32'(ptr_reg) << `LCDT_ST_PTR)
				            | (32'(sub_reg) << `LCDT_ST_SUB)
				            | (32'(row_reg) << `LCDT_ST_ROW)
				            | (32'(mode_i)  << `LCDT_ST_MODE)
				            | (32'(ext_clk) << `LCDT_ST_EXT);
			end else if ((wb_adr_i >= `LCDT_ADR_RAM) && (ram_idx < 10'(COLS))
			             && (wb_adr_i[1:0] == 2'b00)) begin
				// Read-only view of one column
				wb_dat_next = 32'(ram_reg[ram_idx[5:0]]);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_reg     <= `LCDT_CTRL_RST;
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			en_reg     <= en_next;
			wb_ack_reg <= wb_ack_next;
			wb_dat_reg <= wb_dat_next;
		end
	end

	// ============================================================
	// Display register and backplane phases
	logic [COLS-1:0] seg_reg, seg_next;
	logic [3:0]      bp_reg, bp_next;

	always_comb begin
		for (int c = 0; c < COLS; c++) begin
			// One means element on
			seg_next[c] = en_reg & ram_reg[c][row_reg];
		end
		bp_next = 4'h0;
		unique case (mode_i)
			LCDT_STATIC: bp_next = 4'hf;
			LCDT_MUX2: begin
				bp_next[0] = (row_reg == 2'd0);
				bp_next[1] = (row_reg == 2'd1);
				bp_next[2] = (row_reg == 2'd0);
				bp_next[3] = (row_reg == 2'd1);
			end
			LCDT_MUX3: begin
				bp_next[0] = (row_reg == 2'd0);
				bp_next[1] = (row_reg == 2'd1);
				bp_next[2] = (row_reg == 2'd2);
				bp_next[3] = (row_reg == 2'd1);
			end
			LCDT_MUX4: begin
				bp_next[0] = (row_reg == 2'd0);
				bp_next[1] = (row_reg == 2'd1);
				bp_next[2] = (row_reg == 2'd2);
				bp_next[3] = (row_reg == 2'd3);
			end
		endcase
		// Dark panel still needs phases to avoid a DC level
		if (!en_reg) begin
			bp_next = bp_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seg_reg <= '0;
			bp_reg  <= 4'h0;
		end else if (ce_i) begin
			seg_reg <= seg_next;
			bp_reg  <= bp_next;
		end
	end

	// ============================================================
	// Outputs
	assign wb_dat_o          = wb_dat_reg;
	assign wb_ack_o          = wb_ack_reg;
	assign clk_pin_o         = clk_out_reg;
	assign clk_pin_oe_o      = clk_oe_reg;
	assign sync_pin_o        = 1'b0;
	assign sync_pin_oe_o     = sync_oe_reg;
	assign byte_ack_o        = ack_reg;
	assign backplane_out_0_o = bp_reg[0];
	assign backplane_out_1_o = bp_reg[1];
	assign backplane_out_2_o = bp_reg[2];
	assign backplane_out_3_o = bp_reg[3];
	assign segment_out_o     = seg_reg;
	assign frame_rate_o      = fr_reg;

endmodule : lcdt_core

`default_nettype wire

// File: tb/lcdt_host_model.sv
// Host side model driving the command decoder inputs of the core.
// Assumes the testbench calls its tasks from one clocked thread.
`timescale 1ns/10ps
`default_nettype none
module lcdt_host_model
	import lcdt_pkg::*;
(
	// Clock and answer
	input  wire logic  clk_i,
	input  wire logic  byte_ack_i,
	// Decoder side
	output lcdt_mode_t mode_o,
	output logic       ptr_load_o,
	output logic [5:0] ptr_val_o,
	output logic       sub_load_o,
	output logic [2:0] sub_val_o,
	output logic       byte_stb_o,
	output logic [7:0] byte_o
);
	// ============================================================
	// Requests
	initial begin
		mode_o = LCDT_STATIC;
		ptr_load_o = 1'h0;
		ptr_val_o = 6'h0;
		sub_load_o = 1'h0;
		sub_val_o = 3'h0;
		byte_stb_o = 1'h0;
		byte_o = 8'h0;
	end

	task automatic set_mode(input lcdt_mode_t m);
		@(posedge clk_i);
		mode_o <= m;
	endtask : set_mode

	// Pointer reloaded before a burst unless the caller carries it over
	task automatic load(input logic [5:0] p, input logic [2:0] s);
		@(posedge clk_i);
		ptr_load_o <= 1'h1;
		sub_load_o <= 1'h1;
		ptr_val_o <= p;
		sub_val_o <= s;
		@(posedge clk_i);
		ptr_load_o <= 1'h0;
		sub_load_o <= 1'h0;
		ptr_val_o <= ~p;
		sub_val_o <= ~s;
	endtask : load

	task automatic send(input logic [7:0] b, output logic ack);
		@(posedge clk_i);
		byte_stb_o <= 1'h1;
		byte_o <= b;
		@(posedge clk_i);
		byte_stb_o <= 1'h0;
		byte_o <= ~b;
		#1;
		ack = byte_ack_i;
	endtask : send
endmodule : lcdt_host_model
`default_nettype wire

// File: tb/lcdt_core_properties.sv
// Concurrent checks on the ports of the display timing core.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module lcdt_core_chk
	import lcdt_pkg::*;
#(
	parameter int FR_DIV   = 24,
	parameter int OSC_HALF = 8
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        oscillator_select_pin_i,
	input wire logic        clk_pin_oe_o,
	input wire logic        byte_stb_i,
	input wire logic        byte_ack_o,
	input wire lcdt_mode_t  mode_i,
	input wire logic        backplane_out_0_o,
	input wire logic        backplane_out_1_o,
	input wire logic        backplane_out_2_o,
	input wire logic        backplane_out_3_o,
	input wire logic        frame_rate_o
);
	// ============================================================
	// Helper counters
	localparam int PER = FR_DIV * 2 * OSC_HALF;
	int         gap_reg, gap_next, age_reg, age_next;
	logic       ok_reg, ok_next;
	lcdt_mode_t mode_reg;
	wire logic [3:0] bp = {backplane_out_3_o, backplane_out_2_o, backplane_out_1_o,
		backplane_out_0_o};
	// Duplication only judged once rows had time to wrap in the new mode
	wire logic  settled = age_reg > 2 * PER;

	always_comb begin
		gap_next = frame_rate_o ? 0 : gap_reg + 1;
		ok_next = (ok_reg | frame_rate_o) & ce_i & clk_pin_oe_o & ~oscillator_select_pin_i;
		age_next = (mode_i != mode_reg) ? 0 : ((age_reg < 4 * PER) ? age_reg + 1 : age_reg);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap_reg <= 0;
			ok_reg <= 1'h0;
			age_reg <= 0;
			mode_reg <= LCDT_STATIC;
		end else begin
			gap_reg <= gap_next;
			ok_reg <= ok_next;
			age_reg <= age_next;
			mode_reg <= mode_i;
		end
	end

	// ============================================================
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_fr_period: assert property (frame_rate_o && ok_reg |-> gap_reg == PER - 1)
		else $error("frame pulse spacing wrong");
	chk_bp_static: assert property (settled && mode_i == LCDT_STATIC |-> bp == 4'h0 || bp == 4'hf)
		else $error("static backplanes differ");
	chk_bp_dup2: assert property (settled && mode_i == LCDT_MUX2 |-> bp[0] == bp[2] && bp[1] == bp[3])
		else $error("two-backplane duplication broken");
	chk_bp_dup3: assert property (settled && mode_i == LCDT_MUX3 |-> bp[3] == bp[1])
		else $error("three-backplane duplication broken");
	chk_row_order: assert property (settled && mode_i == LCDT_MUX4 && $rose(bp[1]) |-> $past(bp[0]))
		else $error("row 1 not after row 0");
	chk_row_wrap: assert property (settled && mode_i == LCDT_MUX3 && $rose(bp[0]) |-> $past(bp[2]))
		else $error("three-row wrap wrong");
	chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not one pulse after request");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside acknowledge");
	chk_osc_ext: assert property (oscillator_select_pin_i [*6] |-> !clk_pin_oe_o)
		else $error("clock pin driven in external mode");
	chk_osc_int: assert property (!oscillator_select_pin_i [*6] |-> clk_pin_oe_o)
		else $error("clock pin not driven in internal mode");
	chk_byte_ack: assert property (byte_ack_o |-> $past(byte_stb_i))
		else $error("byte acknowledge without strobe");

	cov_ext_frame: cover property (oscillator_select_pin_i && frame_rate_o);
	cov_mux3_wrap: cover property (settled && mode_i == LCDT_MUX3 && $rose(bp[0]));
	cov_no_ack: cover property (byte_stb_i ##1 !byte_ack_o);
endmodule : lcdt_core_chk

bind lcdt_core lcdt_core_chk #(.FR_DIV(FR_DIV), .OSC_HALF(OSC_HALF)) i_lcdt_core_chk (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .oscillator_select_pin_i(oscillator_select_pin_i),
	.clk_pin_oe_o(clk_pin_oe_o), .byte_stb_i(byte_stb_i), .byte_ack_o(byte_ack_o),
	.mode_i(mode_i), .backplane_out_0_o(backplane_out_0_o), .backplane_out_1_o(backplane_out_1_o),
	.backplane_out_2_o(backplane_out_2_o), .backplane_out_3_o(backplane_out_3_o),
	.frame_rate_o(frame_rate_o));
`default_nettype wire

// File: tb/lcdt_core_tb.sv
// Testbench of the display RAM and frame timing core.
// Assumes the host model on the decoder side and a bus master here.
`timescale 1ns/10ps
`default_nettype none
module lcdt_core_tb;
	import lcdt_pkg::*;
	localparam int PER = 24 * 4;
	logic clk_i, rst_i, cyc, stb, we, osc_sel, ext_clk, clk_out, oe, sync_oe, ack_b, fr;
	logic ptr_ld, sub_ld, stb_b, ce;
	logic [11:0] adr;
	logic [31:0] dat, rdat;
	logic wb_ack;
	logic [3:0] bp;
	logic [39:0] seg;
	logic [5:0] ptr_v;
	logic [2:0] sub_v;
	logic [7:0] byte_v;
	logic [1:0] ediv = 2'h0;
	lcdt_mode_t mode;
	int fails = 0;
	int cmp_count = 0;
	int cyc_cnt = 0;
	int mp, ms;
	logic [3:0] ram_m [40];

	// Straps fixed at 5, stable throughout
	lcdt_core #(.OSC_HALF(2)) i_lcdt_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(wb_ack), .oscillator_select_pin_i(osc_sel),
		.clk_pin_i(oe ? clk_out : ext_clk), .clk_pin_o(clk_out), .clk_pin_oe_o(oe),
		.sync_pin_i(~sync_oe), .sync_pin_o(), .sync_pin_oe_o(sync_oe),
		.hw_subaddr_bit_0_i(1'h1), .hw_subaddr_bit_1_i(1'h0), .hw_subaddr_bit_2_i(1'h1),
		.mode_i(mode), .ptr_load_i(ptr_ld), .ptr_val_i(ptr_v), .sub_load_i(sub_ld),
		.sub_val_i(sub_v), .byte_stb_i(stb_b), .byte_i(byte_v), .byte_ack_o(ack_b),
		.backplane_out_0_o(bp[0]), .backplane_out_1_o(bp[1]), .backplane_out_2_o(bp[2]),
		.backplane_out_3_o(bp[3]), .segment_out_o(seg), .frame_rate_o(fr));
	lcdt_host_model i_lcdt_host_model (.clk_i(clk_i), .byte_ack_i(ack_b), .mode_o(mode),
		.ptr_load_o(ptr_ld), .ptr_val_o(ptr_v), .sub_load_o(sub_ld), .sub_val_o(sub_v),
		.byte_stb_o(stb_b), .byte_o(byte_v));

	// ============================================================
	// Clocks and watchdog
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		ediv <= ediv + 2'h1;
		if (osc_sel && ediv == 2'h3)
			ext_clk <= ~ext_clk;
		cyc_cnt++;
		if (cyc_cnt == 12000) begin
			fails++;
			give_verdict;
		end
	end

	// ============================================================
	// Shared tasks
	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			tick(1);
		while (wb_ack !== 1'h1);
		q = rdat;
		@(posedge clk_i);
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask : wb
	task automatic gap(output int n);
		n = 0;
		do
			tick(1);
		while (fr !== 1'h1);
		do begin
			tick(1);
			n++;
		end while (fr !== 1'h1);
	endtask : gap
	// One byte through the host, then pointer, counter and whole RAM
	task automatic step(input lcdt_mode_t m, input logic ld, input logic [5:0] p,
			input logic [2:0] s, input logic [7:0] b);
		int w, col;
		logic hit, ack;
		logic [31:0] q;
		w = int'(m) + 1;
		hit = 1'h0;
		i_lcdt_host_model.set_mode(m);
		if (ld) begin
			i_lcdt_host_model.load(p, s);
			mp = p;
			ms = s;
		end
		for (int n = 0; n < 8; n++) begin
			col = mp + n / w;
			if ((ms + col / 40) % 8 == 5) begin
				ram_m[col % 40][n % w] = b[7 - n];
				hit = 1'h1;
			end
		end
		i_lcdt_host_model.send(b, ack);
		cmp("byte ack", 64'(hit), 64'(ack));
		mp = mp + (7 + w) / w;
		ms = (ms + mp / 40) % 8;
		mp = mp % 40;
		wb(1'h0, 12'h004, 32'h0, q);
		cmp("status", 64'({3'(ms), 6'(mp)}), 64'({q[10:8], q[5:0]}));
		for (int c = 0; c < 40; c++) begin
			wb(1'h0, 12'h100 + 12'(4 * c), 32'h0, q);
			cmp("ram column", 64'(ram_m[c]), 64'(q[3:0]));
		end
	endtask : step

	// ============================================================
	// Scenarios
	task automatic scen_reset;
		logic [31:0] q;
		wb(1'h0, 12'h000, 32'h0, q);
		cmp("control", 64'h1, 64'(q));
		wb(1'h0, 12'h004, 32'h0, q);
		cmp("status", 64'h0, 64'(q));
		wb(1'h0, 12'h800, 32'h0, q);
		cmp("unmapped", 64'h0, 64'(q));
	endtask : scen_reset
	task automatic scen_fill;
		step(LCDT_MUX4, 1'h1, 6'h02, 3'h5, 8'hff);
		step(LCDT_MUX3, 1'h1, 6'h01, 3'h5, 8'h00);
		step(LCDT_MUX4, 1'h1, 6'h26, 3'h5, 8'h5a);
		step(LCDT_MUX2, 1'h1, 6'h24, 3'h5, 8'ha5);
		step(LCDT_STATIC, 1'h1, 6'h25, 3'h5, 8'h96);
		step(LCDT_STATIC, 1'h0, 6'h00, 3'h0, 8'h3c);
		step(LCDT_MUX4, 1'h1, 6'h27, 3'h4, 8'hc7);
	endtask : scen_fill
	task automatic scen_modes;
		for (int m = 0; m < 4; m++) begin
			i_lcdt_host_model.set_mode(lcdt_mode_t'(m));
			tick(3 * PER);
		end
	endtask : scen_modes
	task automatic scen_segments;
		logic [39:0] e;
		logic [31:0] q;
		for (int k = 0; k < 4; k++) begin
			do
				tick(1);
			while (bp[k] !== 1'h1);
			tick(1);
			for (int c = 0; c < 40; c++)
				e[c] = ram_m[c][k];
			cmp("segments", 64'(e), 64'(seg));
		end
		wb(1'h1, 12'h000, 32'h0, q);
		tick(3);
		cmp("blanked segments", 64'h0, 64'(seg));
		wb(1'h1, 12'h000, 32'h1, q);
	endtask : scen_segments
	// Enable low must stretch the frame by exactly the frozen edges
	task automatic scen_freeze;
		int n;
		n = 0;
		do
			tick(1);
		while (fr !== 1'h1);
		@(posedge clk_i);
		ce <= 1'h0;
		repeat (50) @(posedge clk_i);
		ce <= 1'h1;
		do begin
			tick(1);
			n++;
		end while (fr !== 1'h1);
		cmp("frozen frame gap", 64'(PER - 1), 64'(n));
	endtask : scen_freeze
	task automatic scen_clock;
		int n;
		logic [31:0] q;
		scen_freeze;
		gap(n);
		cmp("frame gap", 64'(PER), 64'(n));
		cmp("clock pin drive", 64'h1, 64'(oe));
		@(posedge clk_i);
		osc_sel <= 1'h1;
		tick(8);
		cmp("clock pin drive", 64'h0, 64'(oe));
		wb(1'h0, 12'h004, 32'h0, q);
		cmp("external flag", 64'h1, 64'(q[24]));
		gap(n);
		gap(n);
		cmp("external frame gap", 64'(24 * 8), 64'(n));
		@(posedge clk_i);
		osc_sel <= 1'h0;
		tick(8);
		cmp("clock pin drive", 64'h1, 64'(oe));
	endtask : scen_clock

	initial begin
		rst_i = 1'h1;
		ce = 1'h1;
		cyc = 1'h0;
		stb = 1'h0;
		we = 1'h0;
		adr = 12'h0;
		dat = 32'h0;
		osc_sel = 1'h0;
		ext_clk = 1'h0;
		for (int c = 0; c < 40; c++)
			ram_m[c] = 4'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		scen_reset;
		scen_fill;
		scen_modes;
		scen_segments;
		scen_clock;
		give_verdict;
	end
endmodule : lcdt_core_tb
`default_nettype wire
